// ===== design/eag_pkg.sv
// Package with types and constants for the effective-address generator
// Functional notes
// - File-register-direct: address comes straight from instruction word.
// - Register-direct: working register itself is the operand.
// - Register-indirect: unmodified base pointer is the effective address.
// - Post-modified: access at base, then step base pointer by constant.
// - Pre-modified: add signed constant to base, use result as address.
// - Indexed: address is base plus offset register, both left unchanged.
// - Literal offset: address is base plus instruction literal.
// - Move ops alone also allow indexed, 8-bit and 16-bit literals.
// - Move source and destination modes independent; one offset field.
// - Dual-operand DSP ops use only the reduced prefetch mode set.
// - Pointers eight, nine go to X unit; ten, eleven to Y unit.
// - Indexed prefetch allowed only for pointer nine (X) and eleven (Y).
// - Prefetch modes: indirect, indexed, post-modify by 2, 4 or 6.
// - Branch target is a 16-bit signed literal field.
// - Interrupt-disable count is a 14-bit unsigned literal field.
// - Implied-operand ops take operands from opcode; no-ops carry none.
package eag_pkg;
  localparam int DW = 16;
  localparam logic [15:0] RST_WREG = 16'h0000;
  localparam logic [3:0] PF_X_A = 4'h8;
  localparam logic [3:0] PF_X_B = 4'h9;
  localparam logic [3:0] PF_Y_A = 4'ha;
  localparam logic [3:0] PF_Y_B = 4'hb;
  localparam int LIT_BRANCH_W = 16;
  localparam int LIT_INTERRUPT_DISABLE_OP_W = 14;

  typedef enum logic [3:0] {
    AM_FILE = 4'h0,
    AM_REG = 4'h1,
    AM_IND = 4'h2,
    AM_POST = 4'h3,
    AM_PRE = 4'h4,
    AM_INDEX = 4'h5,
    AM_LITOFS = 4'h6,
    AM_LIT8 = 4'h7,
    AM_LIT16 = 4'h8,
    AM_IMPLIED = 4'h9,
    AM_NONE = 4'ha
  } amode_t;

  typedef enum logic [2:0] {
    CL_ORD = 3'h0,
    CL_MOVE = 3'h1,
    CL_MAC = 3'h2,
    CL_BRANCH = 3'h3,
    CL_INTERRUPT_DISABLE_OP = 3'h4,
    CL_NOP = 3'h5
  } iclass_t;

  typedef enum logic [1:0] {
    PM_IND = 2'h0,
    PM_POST = 2'h1,
    PM_INDEX = 2'h2
  } pfmode_t;

  // One operand address request
  typedef struct packed {
    amode_t mode;
    logic [3:0] base_sel;
    logic signed [15:0] modv;
  } opreq_t;

  // One prefetch request
  typedef struct packed {
    logic en;
    pfmode_t mode;
    logic [3:0] ptr;
    logic [1:0] step;
    logic dec;
  } pfreq_t;

  // One generated address
  typedef struct packed {
    logic valid;
    logic is_reg;
    logic [15:0] addr;
  } eaout_t;
endpackage

// ===== design/eag_prefetch_unit.sv
// One prefetch address unit (X or Y) for dual-operand DSP reads
`timescale 1ns/1ns
module eag_prefetch_unit #(
  parameter logic [3:0] PTR_A = 4'h8,
  parameter logic [3:0] PTR_B = 4'h9
) (
  input wire logic en,
  input wire eag_pkg::pfmode_t mode,
  input wire logic [3:0] ptr,
  input wire logic [1:0] step,
  input wire logic dec,
  input wire logic [15:0] ptr_a_val,
  input wire logic [15:0] ptr_b_val,
  input wire logic [15:0] ofs_val,
  output logic ok,
  output logic [15:0] addr,
  output logic wb_en,
  output logic [15:0] wb_val
);
  logic [15:0] base;
  logic [15:0] amt;
  always_comb begin
    base = (ptr == PTR_B) ? ptr_b_val : ptr_a_val;
    amt = {13'h0, step, 1'b0};
    ok = en && (ptr == PTR_A || ptr == PTR_B);
    if (mode == eag_pkg::PM_INDEX && ptr != PTR_B) begin
      ok = 1'b0;
    end
    if (mode == eag_pkg::PM_POST && step == 2'h0) begin
      ok = 1'b0;
    end
    addr = (mode == eag_pkg::PM_INDEX) ? base + ofs_val : base;
    wb_en = ok && mode == eag_pkg::PM_POST;
    wb_val = dec ? base - amt : base + amt;
  end
endmodule // eag_prefetch_unit

// ===== design/effective_address_generator.sv
// Effective-address generator with working register file
`timescale 1ns/1ns
module effective_address_generator (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic REQ,
  input wire eag_pkg::iclass_t ICLASS,
  input wire eag_pkg::opreq_t SRC,
  input wire eag_pkg::opreq_t DST,
  input wire logic [3:0] OFS_SEL,
  input wire logic [15:0] FILE_ADDR,
  input wire logic [15:0] LIT,
  input wire eag_pkg::pfreq_t PFX,
  input wire eag_pkg::pfreq_t PFY,
  input wire logic WR_EN,
  input wire logic [3:0] WR_SEL,
  input wire logic [15:0] WR_DATA,
  output eag_pkg::eaout_t SRC_EA,
  output eag_pkg::eaout_t DST_EA,
  output eag_pkg::eaout_t X_EA,
  output eag_pkg::eaout_t Y_EA,
  output logic [15:0] OPERAND,
  output logic [15:0] BRANCH_TARGET,
  output logic [13:0] INTERRUPT_DISABLE_OP_COUNT,
  output logic ILLEGAL
);
  logic [15:0] wreg_r [16];
  logic [15:0] ofs_val;
  eag_pkg::eaout_t src_nxt;
  eag_pkg::eaout_t dst_nxt;
  logic src_wb;
  logic dst_wb;
  logic [15:0] src_wbv;
  logic [15:0] dst_wbv;
  logic bad_nxt;
  logic x_ok;
  logic y_ok;
  logic x_wb;
  logic y_wb;
  logic [15:0] x_addr;
  logic [15:0] y_addr;
  logic [15:0] x_wbv;
  logic [15:0] y_wbv;
  logic [15:0] operand_nxt;

  assign ofs_val = wreg_r[OFS_SEL];

  function automatic eag_pkg::eaout_t gen_ea(
    input eag_pkg::opreq_t rq,
    input logic [15:0] base,
    input logic [15:0] ofs,
    input logic [15:0] faddr,
    input logic [15:0] lit
  );
    eag_pkg::eaout_t r;
    r = '0;
    r.valid = 1'b1;
    case (rq.mode)
      eag_pkg::AM_FILE: r.addr = faddr;
      eag_pkg::AM_REG: begin
        r.valid = 1'b0;
        r.is_reg = 1'b1;
      end
      eag_pkg::AM_IND: r.addr = base;
      eag_pkg::AM_POST: r.addr = base;
      eag_pkg::AM_PRE: r.addr = base + rq.modv;
      eag_pkg::AM_INDEX: r.addr = base + ofs;
      eag_pkg::AM_LITOFS: r.addr = base + lit;
      default: r.valid = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic mode_bad(
    input eag_pkg::opreq_t rq,
    input eag_pkg::iclass_t cl
  );
    logic b;
    b = 1'b0;
    if (cl != eag_pkg::CL_MOVE && (rq.mode == eag_pkg::AM_INDEX ||
        rq.mode == eag_pkg::AM_LIT8 || rq.mode == eag_pkg::AM_LIT16)) begin
      b = 1'b1;
    end
    if (rq.mode > eag_pkg::AM_NONE) begin
      b = 1'b1;
    end
    return b;
  endfunction

  eag_prefetch_unit #(.PTR_A(eag_pkg::PF_X_A), .PTR_B(eag_pkg::PF_X_B)) u_x (
    .en(PFX.en),
    .mode(PFX.mode),
    .ptr(PFX.ptr),
    .step(PFX.step),
    .dec(PFX.dec),
    .ptr_a_val(wreg_r[eag_pkg::PF_X_A]),
    .ptr_b_val(wreg_r[eag_pkg::PF_X_B]),
    .ofs_val(ofs_val),
    .ok(x_ok),
    .addr(x_addr),
    .wb_en(x_wb),
    .wb_val(x_wbv)
  );

  eag_prefetch_unit #(.PTR_A(eag_pkg::PF_Y_A), .PTR_B(eag_pkg::PF_Y_B)) u_y (
    .en(PFY.en),
    .mode(PFY.mode),
    .ptr(PFY.ptr),
    .step(PFY.step),
    .dec(PFY.dec),
    .ptr_a_val(wreg_r[eag_pkg::PF_Y_A]),
    .ptr_b_val(wreg_r[eag_pkg::PF_Y_B]),
    .ofs_val(ofs_val),
    .ok(y_ok),
    .addr(y_addr),
    .wb_en(y_wb),
    .wb_val(y_wbv)
  );

  always_comb begin
    src_nxt = '0;
    dst_nxt = '0;
    src_wb = 1'b0;
    dst_wb = 1'b0;
    src_wbv = wreg_r[SRC.base_sel] + SRC.modv;
    dst_wbv = wreg_r[DST.base_sel] + DST.modv;
    bad_nxt = 1'b0;
    operand_nxt = OPERAND;
    case (ICLASS)
      eag_pkg::CL_ORD, eag_pkg::CL_MOVE: begin
        src_nxt = gen_ea(SRC, wreg_r[SRC.base_sel], ofs_val, FILE_ADDR, LIT);
        dst_nxt = gen_ea(DST, wreg_r[DST.base_sel], ofs_val, FILE_ADDR, LIT);
        bad_nxt = mode_bad(SRC, ICLASS) || mode_bad(DST, ICLASS);
        src_wb = SRC.mode == eag_pkg::AM_POST || SRC.mode == eag_pkg::AM_PRE;
        dst_wb = DST.mode == eag_pkg::AM_POST || DST.mode == eag_pkg::AM_PRE;
        if (SRC.mode == eag_pkg::AM_REG) begin
          operand_nxt = wreg_r[SRC.base_sel];
        end else if (SRC.mode == eag_pkg::AM_LIT8) begin
          operand_nxt = {8'h00, LIT[7:0]};
        end else if (SRC.mode == eag_pkg::AM_LIT16) begin
          operand_nxt = LIT;
        end
      end
      eag_pkg::CL_MAC: begin
        // Only the prefetch units may address memory for this class
        bad_nxt = (PFX.en && !x_ok) || (PFY.en && !y_ok) ||
                  (SRC.mode != eag_pkg::AM_NONE &&
                   SRC.mode != eag_pkg::AM_IMPLIED) ||
                  (DST.mode != eag_pkg::AM_NONE &&
                   DST.mode != eag_pkg::AM_IMPLIED);
      end
      default: begin
        src_nxt = '0;
      end
    endcase
  end

  // Working registers: decoder write, then pointer write-back on top
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < 16; i++) begin
        wreg_r[i] <= eag_pkg::RST_WREG;
      end
    end else begin
      if (WR_EN) begin
        wreg_r[WR_SEL] <= WR_DATA;
      end
      if (REQ && !bad_nxt) begin
        if (ICLASS == eag_pkg::CL_MAC) begin
          if (x_wb) begin
            wreg_r[PFX.ptr] <= x_wbv;
          end
          if (y_wb) begin
            wreg_r[PFY.ptr] <= y_wbv;
          end
        end else if (ICLASS == eag_pkg::CL_ORD ||
                     ICLASS == eag_pkg::CL_MOVE) begin
          if (src_wb) begin
            wreg_r[SRC.base_sel] <= src_wbv;
          end
          if (dst_wb) begin
            wreg_r[DST.base_sel] <= dst_wbv;
          end
        end
      end
    end
  end

  // Address outputs
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      SRC_EA <= '0;
      DST_EA <= '0;
      X_EA <= '0;
      Y_EA <= '0;
      ILLEGAL <= 1'b0;
    end else begin
      ILLEGAL <= REQ && bad_nxt;
      SRC_EA <= (REQ && !bad_nxt) ? src_nxt : '0;
      DST_EA <= (REQ && !bad_nxt) ? dst_nxt : '0;
      X_EA <= '0;
      Y_EA <= '0;
      if (REQ && !bad_nxt && ICLASS == eag_pkg::CL_MAC) begin
        X_EA <= '{valid: x_ok, is_reg: 1'b0, addr: x_addr};
        Y_EA <= '{valid: y_ok, is_reg: 1'b0, addr: y_addr};
      end
    end
  end

  // Literal fields
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      OPERAND <= 16'h0000;
      BRANCH_TARGET <= 16'h0000;
      INTERRUPT_DISABLE_OP_COUNT <= 14'h0000;
    end else if (REQ) begin
      OPERAND <= operand_nxt;
      if (ICLASS == eag_pkg::CL_BRANCH) begin
        BRANCH_TARGET <= LIT[eag_pkg::LIT_BRANCH_W-1:0];
      end
      if (ICLASS == eag_pkg::CL_INTERRUPT_DISABLE_OP) begin
        INTERRUPT_DISABLE_OP_COUNT <= LIT[eag_pkg::LIT_INTERRUPT_DISABLE_OP_W-1:0];
      end
    end
  end

  a_file_direct: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && !bad_nxt && ICLASS == eag_pkg::CL_ORD &&
    SRC.mode == eag_pkg::AM_FILE |=> SRC_EA.addr == $past(FILE_ADDR))
    else $error("file direct address wrong");
  a_reg_direct: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && !bad_nxt && ICLASS == eag_pkg::CL_ORD &&
    SRC.mode == eag_pkg::AM_REG |=> !SRC_EA.valid && SRC_EA.is_reg)
    else $error("register direct made an address");
  a_post_step: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && !bad_nxt && ICLASS == eag_pkg::CL_ORD && !WR_EN &&
    SRC.mode == eag_pkg::AM_POST && !dst_wb
    |=> SRC_EA.addr == $past(wreg_r[SRC.base_sel]) &&
        wreg_r[$past(SRC.base_sel)] ==
        $past(wreg_r[SRC.base_sel] + SRC.modv))
    else $error("post-modify wrong");
  a_pre_addr: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && !bad_nxt && ICLASS == eag_pkg::CL_ORD &&
    SRC.mode == eag_pkg::AM_PRE
    |=> SRC_EA.addr == $past(wreg_r[SRC.base_sel] + SRC.modv))
    else $error("pre-modify address wrong");
  a_index_addr: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && !bad_nxt && ICLASS == eag_pkg::CL_MOVE &&
    SRC.mode == eag_pkg::AM_INDEX
    |=> SRC_EA.addr == $past(wreg_r[SRC.base_sel] + ofs_val))
    else $error("indexed address wrong");
  a_lit_offset: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && !bad_nxt && ICLASS == eag_pkg::CL_ORD &&
    SRC.mode == eag_pkg::AM_LITOFS
    |=> SRC_EA.addr == $past(wreg_r[SRC.base_sel] + LIT))
    else $error("literal offset address wrong");
  a_ord_no_index: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_ORD && SRC.mode == eag_pkg::AM_INDEX
    |=> ILLEGAL && !SRC_EA.valid)
    else $error("indexed accepted on ordinary op");
  a_move_lit8: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_MOVE && SRC.mode == eag_pkg::AM_LIT8
    |=> OPERAND == {8'h00, $past(LIT[7:0])})
    else $error("short literal operand wrong");
  a_mac_no_src: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_MAC && SRC.mode == eag_pkg::AM_IND
    |=> ILLEGAL && !X_EA.valid && !Y_EA.valid)
    else $error("general operand accepted on dual-operand op");
  a_pf_route: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_MAC && PFX.en && PFX.ptr == eag_pkg::PF_Y_A
    |=> ILLEGAL && !X_EA.valid)
    else $error("Y pointer routed to X unit");
  a_pf_index: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_MAC && PFX.en &&
    PFX.mode == eag_pkg::PM_INDEX && PFX.ptr == eag_pkg::PF_X_A
    |=> ILLEGAL)
    else $error("indexed prefetch on wrong pointer");
  a_pf_post_wb: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && !bad_nxt && ICLASS == eag_pkg::CL_MAC &&
    PFX.en && PFX.mode == eag_pkg::PM_POST && !PFX.dec
    |=> wreg_r[$past(PFX.ptr)] ==
        $past(wreg_r[PFX.ptr]) + $past({13'h0, PFX.step, 1'b0}))
    else $error("prefetch post-modify write-back wrong");
  a_branch_lit: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_BRANCH |=> BRANCH_TARGET == $past(LIT))
    else $error("branch literal wrong");
  a_interrupt_disable_op_lit: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_INTERRUPT_DISABLE_OP
    |=> INTERRUPT_DISABLE_OP_COUNT == $past(LIT[13:0]))
    else $error("disable count wrong");
  a_implied_none: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_NOP
    |=> !SRC_EA.valid && !DST_EA.valid && !ILLEGAL)
    else $error("no-operand op produced an address");
  c_mac_post: cover property (@(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_MAC && (x_wb || y_wb));
  c_move_index: cover property (@(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_MOVE && SRC.mode == eag_pkg::AM_INDEX);
  c_branch: cover property (@(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_BRANCH);
  c_mac_refused: cover property (@(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_MAC && bad_nxt);
  c_move_pre: cover property (@(posedge SYS_CLK) disable iff (RESET)
    REQ && ICLASS == eag_pkg::CL_MOVE && DST.mode == eag_pkg::AM_PRE);
endmodule // effective_address_generator

// ===== bench/xy_data_mem.sv
// Behavioural X/Y data memory port counting reads outside their space
`timescale 1ns/1ns
module xy_data_mem #(
  parameter logic [15:0] X_TOP = 16'h7fff,
  parameter logic [15:0] Y_BASE = 16'h8000
) (
  input wire logic clk,
  input wire eag_pkg::eaout_t x_ea,
  input wire eag_pkg::eaout_t y_ea,
  output logic [7:0] strays
);
  logic x_bad;
  logic y_bad;
  logic [7:0] cnt = 8'h00;
  assign x_bad = x_ea.valid && x_ea.addr > X_TOP;
  assign y_bad = y_ea.valid && y_ea.addr < Y_BASE;
  assign strays = cnt;
  always @(posedge clk) begin
    cnt <= cnt + 8'(x_bad) + 8'(y_bad);
  end
endmodule // xy_data_mem

// ===== bench/effective_address_generator_test.sv
// Self-checking testbench for the effective-address generator
`timescale 1ns/1ns
module effective_address_generator_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  eag_pkg::iclass_t cl = eag_pkg::CL_NOP;
  eag_pkg::opreq_t nn = {eag_pkg::AM_NONE, 4'h0, 16'h0000};
  eag_pkg::opreq_t src = nn;
  eag_pkg::opreq_t dst = nn;
  eag_pkg::pfreq_t p0 = '0;
  eag_pkg::pfreq_t pfx = '0;
  eag_pkg::pfreq_t pfy = '0;
  logic [3:0] ofs = 4'h7;
  logic [15:0] fa = 16'h0000;
  logic [15:0] lit = 16'h0000;
  logic we = 1'b0;
  logic [3:0] ws = 4'h0;
  logic [15:0] wd = 16'h0000;
  eag_pkg::eaout_t s_ea, d_ea, x_ea, y_ea;
  logic [15:0] opnd, btgt, e;
  logic [13:0] dcnt;
  logic ill;
  logic [7:0] strays;
  logic [15:0] w [16];
  eag_pkg::amode_t tbl [6] = '{eag_pkg::AM_FILE, eag_pkg::AM_REG,
    eag_pkg::AM_IND, eag_pkg::AM_POST, eag_pkg::AM_PRE, eag_pkg::AM_LITOFS};
  eag_pkg::pfreq_t bad [4] = '{{1'b1, eag_pkg::PM_IND, 4'ha, 2'h1, 1'b0},
    {1'b1, eag_pkg::PM_INDEX, 4'h8, 2'h1, 1'b0},
    {1'b1, eag_pkg::PM_POST, 4'h8, 2'h0, 1'b0},
    {1'b1, eag_pkg::PM_POST, 4'h8, 2'h1, 1'b0}};
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 32'hfc2f68a0;
  int r;
  always #5 clk = ~clk;
  effective_address_generator uut (.SYS_CLK(clk), .RESET(rst), .REQ(req),
    .ICLASS(cl), .SRC(src), .DST(dst), .OFS_SEL(ofs), .FILE_ADDR(fa),
    .LIT(lit), .PFX(pfx), .PFY(pfy), .WR_EN(we), .WR_SEL(ws), .WR_DATA(wd),
    .SRC_EA(s_ea), .DST_EA(d_ea), .X_EA(x_ea), .Y_EA(y_ea), .OPERAND(opnd),
    .BRANCH_TARGET(btgt), .INTERRUPT_DISABLE_OP_COUNT(dcnt), .ILLEGAL(ill));
  xy_data_mem mem (.clk(clk), .x_ea(x_ea), .y_ea(y_ea), .strays(strays));
  function automatic eag_pkg::opreq_t mk(input eag_pkg::amode_t m,
      input logic [3:0] b, input logic [15:0] v);
    return {m, b, v};
  endfunction
  function automatic eag_pkg::eaout_t ea(input logic [15:0] a);
    return {1'b1, 1'b0, a};
  endfunction
  task automatic chk_ea(input string nm, input eag_pkg::eaout_t x,
      input eag_pkg::eaout_t g);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic chk_w(input string nm, input logic [15:0] x,
      input logic [15:0] g);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One instruction; the answer is checked in the following cycle
  task automatic op(input eag_pkg::iclass_t c, input eag_pkg::opreq_t s,
      input eag_pkg::opreq_t d, input eag_pkg::pfreq_t px,
      input eag_pkg::pfreq_t py);
    cl = c;
    src = s;
    dst = d;
    pfx = px;
    pfy = py;
    req = 1'b1;
    @(posedge clk);
    #1;
  endtask
  task automatic sweep();
    for (int i = 0; i < 16; i++) begin
      op(eag_pkg::CL_ORD, mk(eag_pkg::AM_IND, i[3:0], 16'h0), nn, p0, p0);
      chk_ea("src_ea", ea(w[i]), s_ea);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    op(eag_pkg::CL_ORD, mk(eag_pkg::AM_IND, 4'h5, 16'h0), nn, p0, p0);
    chk_ea("src_ea", ea(eag_pkg::RST_WREG), s_ea);
    req = 1'b0;
    we = 1'b1;
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      wd = i == 7 ? 16'h0010 : i < 8 ? {r[15:1], 1'b0}
        : {i > 9, 3'h1, r[11:1], 1'b0};
      ws = i[3:0];
      w[i] = wd;
      @(posedge clk);
      #1;
    end
    we = 1'b0;
    chk_ea("src_ea idle", '0, s_ea);
    for (int i = 0; i < 60; i++) begin
      eag_pkg::amode_t m;
      logic [3:0] b;
      logic [15:0] v;
      r = $random(seed);
      m = tbl[r[2:0] % 3'h6];
      b = {1'b0, r[10:8] % 3'h7};
      v = {{11{r[15]}}, r[15:12], 1'b0};
      fa = r[31:16];
      lit = {r[23:16], r[31:24]};
      op(eag_pkg::CL_ORD, mk(m, b, v), nn, p0, p0);
      e = w[b] + (m == eag_pkg::AM_PRE ? v : 16'h0)
        + (m == eag_pkg::AM_LITOFS ? lit : 16'h0);
      if (m == eag_pkg::AM_FILE) e = fa;
      if (m == eag_pkg::AM_REG) chk_w("operand", w[b], opnd);
      else chk_ea("src_ea", ea(e), s_ea);
      if (m == eag_pkg::AM_POST || m == eag_pkg::AM_PRE) w[b] = w[b] + v;
      chk_w("illegal", 16'h0, {15'h0, ill});
    end
    ofs = 4'h3;
    op(eag_pkg::CL_MOVE, mk(eag_pkg::AM_INDEX, 4'h1, 16'h0),
      mk(eag_pkg::AM_POST, 4'h2, 16'h0004), p0, p0);
    chk_ea("src_ea", ea(w[1] + w[3]), s_ea);
    chk_ea("dst_ea", ea(w[2]), d_ea);
    w[2] = w[2] + 16'h0004;
    lit = r[15:0];
    op(eag_pkg::CL_MOVE, mk(eag_pkg::AM_LIT8, 4'h0, 16'h0),
      mk(eag_pkg::AM_PRE, 4'h4, 16'hfffe), p0, p0);
    w[4] = w[4] - 16'h0002;
    chk_w("operand", {8'h00, lit[7:0]}, opnd);
    chk_ea("dst_ea", ea(w[4]), d_ea);
    op(eag_pkg::CL_MOVE, mk(eag_pkg::AM_LIT16, 4'h0, 16'h0), nn, p0, p0);
    chk_w("operand", lit, opnd);
    op(eag_pkg::CL_ORD, mk(eag_pkg::AM_INDEX, 4'h1, 16'h0), nn, p0, p0);
    chk_w("illegal", 16'h1, {15'h0, ill});
    chk_ea("src_ea", '0, s_ea);
    sweep();
    ofs = 4'h7;
    for (int i = 0; i < 6; i++) begin
      logic [3:0] pp;
      logic [3:0] ip;
      logic [1:0] st;
      eag_pkg::pfreq_t qp;
      eag_pkg::pfreq_t qi;
      pp = i[0] ? 4'ha : 4'h8;
      ip = i[0] ? 4'h9 : 4'hb;
      st = 2'(i % 3 + 1);
      qp = {1'b1, eag_pkg::PM_POST, pp, st, i > 2};
      qi = {1'b1, eag_pkg::PM_INDEX, ip, 2'h0, 1'b0};
      op(eag_pkg::CL_MAC, nn, nn, i[0] ? qi : qp, i[0] ? qp : qi);
      e = i[0] ? w[9] + w[7] : w[8];
      chk_ea("x_ea", ea(e), x_ea);
      e = i[0] ? w[10] : w[11] + w[7];
      chk_ea("y_ea", ea(e), y_ea);
      e = {13'h0, st, 1'b0};
      w[pp] = i > 2 ? w[pp] - e : w[pp] + e;
    end
    for (int i = 0; i < 4; i++) begin
      op(eag_pkg::CL_MAC, i == 3 ? mk(eag_pkg::AM_IND, 4'h1, 16'h0) : nn,
        nn, bad[i], p0);
      chk_w("illegal", 16'h1, {15'h0, ill});
      chk_ea("x_ea", '0, x_ea);
    end
    sweep();
    lit = r[15:0] | 16'h8000;
    op(eag_pkg::CL_BRANCH, nn, nn, p0, p0);
    chk_w("branch", lit, btgt);
    lit = 16'hffff;
    op(eag_pkg::CL_INTERRUPT_DISABLE_OP, nn, nn, p0, p0);
    chk_w("interrupt_disable_op", 16'h3fff, {2'h0, dcnt});
    op(eag_pkg::CL_NOP, nn, nn, p0, p0);
    chk_ea("src_ea", '0, s_ea);
    chk_w("illegal", 16'h0, {15'h0, ill});
    req = 1'b0;
    @(posedge clk);
    #1;
    chk_w("strays", 16'h0, {8'h00, strays});
    give_verdict();
  end
endmodule // effective_address_generator_test
